// ===== hw/fula_pkg.sv
// Shared constants and types for the flash update loader
package fula_pkg;

	// ==========================================================
	// Command identifiers
	localparam logic [7:0] CMD_ENTER   = 8'h55;
	localparam logic [7:0] CMD_LEAVE   = 8'h10;
	localparam logic [7:0] CMD_OPEN    = 8'h11;
	localparam logic [7:0] CMD_ERASE   = 8'h12;
	localparam logic [7:0] CMD_ADDR    = 8'h13;
	localparam logic [7:0] CMD_FILL    = 8'h14;
	localparam logic [7:0] CMD_COMMIT  = 8'h15;
	localparam logic [7:0] CMD_CHECK   = 8'h16;
	localparam logic [7:0] CMD_READ    = 8'h17;
	localparam logic [7:0] CMD_VERSION = 8'hFF;

	// ==========================================================
	// Packet lengths (bytes after the length byte)
	localparam logic [7:0]  LEN_SIMPLE   = 8'h01;
	localparam logic [7:0]  LEN_OPEN     = 8'h0A;
	localparam logic [7:0]  LEN_ADDR     = 8'h05;
	localparam logic [7:0]  LEN_READ     = 8'h03;
	localparam logic [7:0]  LEN_FILL_HDR = 8'h05;
	localparam logic [7:0]  REPLY_LEN    = 8'h02;
	localparam logic [15:0] FILL_MAX     = 16'h0036;
	localparam int          ARG_BYTES    = 9;

	// ==========================================================
	// Reply status codes
	localparam logic [7:0] ST_OK      = 8'h00;
	localparam logic [7:0] ST_CSUM    = 8'h07;
	localparam logic [7:0] ST_FLASH   = 8'h08;
	localparam logic [7:0] ST_RANGE   = 8'h0A;
	localparam logic [7:0] ST_NOSESS  = 8'h0B;
	localparam logic [7:0] ST_UNKNOWN = 8'h0C;
	localparam logic [7:0] ST_COUNT   = 8'h0D;
	localparam logic [7:0] ST_LEAVE   = 8'h0E;

	// ==========================================================
	// Page geometry and timing
	localparam int PAGE_BYTES    = 4096;
	localparam int PAGE_AW       = 12;
	localparam int CLK_PERIOD_NS = 100;
	localparam int DETACH_NS     = 10000;
	localparam int DETACH_CYC    = (DETACH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		FOP_NONE,
		FOP_ERASE,
		FOP_PROGRAM,
		FOP_CHECK,
		FOP_READ
	} fula_op_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} fula_byte_t;

	typedef struct packed {
		fula_op_t    op;
		logic [31:0] addr;
		logic [31:0] end_addr;
		logic [15:0] len;
	} fula_flash_req_t;

endpackage

// ===== hw/fula_page_buf.sv
// Flip-flop page buffer with one write and one registered read port
`timescale 1ns/1ps
module fula_page_buf #(
	parameter int DEPTH = 4096,
	parameter int AW    = 12
) (
	// Clock and reset
	input  wire logic          i_clk_sys,
	input  wire logic          i_rstn,
	// Write port
	input  wire logic          i_wr_en,
	input  wire logic [AW-1:0] i_wr_idx,
	input  wire logic [7:0]    i_wr_data,
	// Read port
	input  wire logic [AW-1:0] i_rd_idx,
	output logic      [7:0]    o_rd_data
);
	logic [7:0] mem [0:DEPTH-1];
	logic [7:0] next_rd_data;

	always_comb begin
		next_rd_data = mem[i_rd_idx];
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_wr_en) begin
			mem[i_wr_idx] <= i_wr_data;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rd_data <= 8'h00;
		end else begin
			o_rd_data <= next_rd_data;
		end
	end
endmodule

// ===== hw/fula_loader.sv
// Packet command interpreter of the flash update loader
`timescale 1ns/1ps
// Behaviour
// - Starts in application mode; loader commands only after enter command.
// - Enter command identifier is 0x55.
// - Entering or leaving over USB detaches and re-enumerates with loader identity.
// - Decodes 0x10 through 0x17 and 0xFF as loader commands.
// - No erase or program of ROM before a session is open.
// - Session open marks application unstable; leaving refused until update completes.
// - Session open: length 0x0A, type byte, start and end addresses.
// - Page address: length 0x05, four bytes LSB first, 4 KB aligned.
// - Page erase erases the page at the held page address.
// - RAM fill: size and offset LSB first, at most 54 payload bytes.
// - RAM fill payload stored at offset, length taken from size field.
// - Page commit programs buffered data at the held page address.
// - Leave returns to application only when a valid application exists.
// - Firmware check reads the flash section of the session.
// - Flash read: length 0x03, 16-bit count LSB first, returns ROM bytes.
// - Version query reports the loader revision.
// - Status 0x00, 0x07, 0x08, 0x0A, 0x0D for the documented outcomes.
// - Status 0x0B no session, 0x0C unknown command, 0x0E leave failed.
// - Every reply is length 0x02, echoed identifier, status byte; a version reply with status 0x00 adds a revision byte.
module fula_loader #(
	parameter int          PAGE_BYTES = fula_pkg::PAGE_BYTES,
	parameter int          PAGE_AW    = fula_pkg::PAGE_AW,
	parameter int          DETACH_CYC = fula_pkg::DETACH_CYC,
	parameter logic [7:0]  LOADER_REV = 8'h01,
	parameter logic [15:0] LOADER_VID = 16'h1234,
	parameter logic [15:0] LOADER_PID = 16'h5678
) (
	// Clock and reset
	input  wire logic                      i_clk_sys,
	input  wire logic                      i_rstn,
	// Command byte stream
	input  wire fula_pkg::fula_byte_t      i_rx,
	output logic                           o_rx_ready,
	// Reply byte stream
	output fula_pkg::fula_byte_t           o_tx,
	input  wire logic                      i_tx_ready,
	// Flash engine
	output fula_pkg::fula_flash_req_t      o_flash_req,
	input  wire logic                      i_flash_done,
	input  wire logic                      i_flash_fail,
	input  wire logic                      i_flash_sum_bad,
	input  wire fula_pkg::fula_byte_t      i_flash_rd,
	output logic                           o_flash_rd_ready,
	input  wire logic [PAGE_AW-1:0]        i_buf_rd_idx,
	output logic      [7:0]                o_buf_rd_data,
	// Mode and USB identity
	input  wire logic                      i_app_valid,
	input  wire logic                      i_usb_host,
	output logic                           o_loader_mode,
	output logic                           o_usb_detach,
	output logic      [15:0]               o_usb_vid,
	output logic      [15:0]               o_usb_pid
);
	import fula_pkg::*;

	typedef enum logic [2:0] {S_LEN, S_ID, S_BODY, S_EXEC, S_WAIT, S_REPLY, S_STREAM} fula_state_t;

	// ==========================================================
	// State
	fula_state_t     state,      next_state;
	logic [7:0]      pkt_len,    next_pkt_len;
	logic [7:0]      rem,        next_rem;
	logic [7:0]      cmd_id,     next_cmd_id;
	logic [7:0]      bidx,       next_bidx;
	logic [8:0][7:0] arg,        next_arg;
	logic [7:0]      status,     next_status;
	logic [1:0]      ridx,       next_ridx;
	fula_op_t        op,         next_op;
	logic [15:0]     rd_left,    next_rd_left;
	logic            tx_full,    next_tx_full;
	logic [7:0]      tx_data,    next_tx_data;
	logic            loader,     next_loader;
	logic            sess,       next_sess;
	logic            unstable,   next_unstable;
	logic            page_set,   next_page_set;
	logic [31:0]     page_addr,  next_page_addr;
	logic [31:0]     sess_start, next_sess_start;
	logic [31:0]     sess_end,   next_sess_end;
	logic [15:0]     det_cnt,    next_det_cnt;

	logic               rx_take;
	logic               tx_take;
	logic               tx_free;
	logic [15:0]        fill_size;
	logic [15:0]        fill_off;
	logic               fill_fits;
	logic               fill_count_ok;
	logic               buf_wr;
	logic [PAGE_AW-1:0] buf_idx;
	logic [31:0]        arg_addr;
	logic [31:0]        open_start;
	logic [31:0]        open_end;
	logic               rd_take;
	logic               reply_last;

	function automatic logic is_known(input logic [7:0] id);
		return id inside {CMD_LEAVE, CMD_OPEN, CMD_ERASE, CMD_ADDR, CMD_FILL,
			CMD_COMMIT, CMD_CHECK, CMD_READ, CMD_VERSION};
	endfunction

	function automatic logic [7:0] exp_len(input logic [7:0] id);
		case (id)
			CMD_OPEN: return LEN_OPEN;
			CMD_ADDR: return LEN_ADDR;
			CMD_READ: return LEN_READ;
			default:  return LEN_SIMPLE;
		endcase
	endfunction

	function automatic logic aligned(input logic [31:0] a);
		return a[PAGE_AW-1:0] == '0;
	endfunction

	// ==========================================================
	// Datapath terms
	assign o_rx_ready = (state == S_LEN) || (state == S_ID) || (state == S_BODY);
	assign rx_take    = i_rx.valid && o_rx_ready;
	assign tx_take    = tx_full && i_tx_ready;
	assign tx_free    = !tx_full || tx_take;
	assign fill_size  = {arg[1], arg[0]};
	assign fill_off   = {arg[3], arg[2]};
	assign fill_count_ok = ({8'h00, pkt_len} == fill_size + 16'd5) && (fill_size <= FILL_MAX);
	assign fill_fits  = ({1'b0, fill_off} + {1'b0, fill_size}) <= 17'(PAGE_BYTES);
	assign buf_wr     = (state == S_BODY) && rx_take && (cmd_id == CMD_FILL) && (bidx >= 8'd4)
		&& loader && sess && fill_count_ok && fill_fits;
	assign buf_idx    = PAGE_AW'(fill_off + {8'h00, bidx} - 16'd4);
	assign arg_addr   = {arg[3], arg[2], arg[1], arg[0]};
	assign open_start = {arg[4], arg[3], arg[2], arg[1]};
	assign open_end   = {arg[8], arg[7], arg[6], arg[5]};
	assign o_flash_rd_ready = (state == S_STREAM) && tx_free && (rd_left != 16'h0000);
	assign rd_take    = i_flash_rd.valid && o_flash_rd_ready;
	assign reply_last = (ridx == 2'd3) ||
		((ridx == 2'd2) && !((cmd_id == CMD_VERSION) && (status == ST_OK)));

	// ==========================================================
	// Interpreter next state
	always_comb begin
		next_state      = state;
		next_pkt_len    = pkt_len;
		next_rem        = rem;
		next_cmd_id     = cmd_id;
		next_bidx       = bidx;
		next_arg        = arg;
		next_status     = status;
		next_ridx       = ridx;
		next_op         = op;
		next_rd_left    = rd_left;
		next_tx_full    = tx_take ? 1'b0 : tx_full;
		next_tx_data    = tx_data;
		next_loader     = loader;
		next_sess       = sess;
		next_unstable   = unstable;
		next_page_set   = page_set;
		next_page_addr  = page_addr;
		next_sess_start = sess_start;
		next_sess_end   = sess_end;
		case (state)
			S_LEN: begin
				if (rx_take && (i_rx.data != 8'h00)) begin
					next_pkt_len = i_rx.data;
					next_state   = S_ID;
				end
			end
			S_ID: begin
				if (rx_take) begin
					next_cmd_id = i_rx.data;
					next_rem    = pkt_len - 8'd1;
					next_bidx   = 8'h00;
					next_state  = (pkt_len == LEN_SIMPLE) ? S_EXEC : S_BODY;
				end
			end
			S_BODY: begin
				if (rx_take) begin
					if (bidx < 8'(ARG_BYTES)) begin
						next_arg[bidx[3:0]] = i_rx.data;
					end
					next_bidx = bidx + 8'd1;
					next_rem  = rem - 8'd1;
					if (rem == 8'd1) begin
						next_state = S_EXEC;
					end
				end
			end
			S_EXEC: begin
				next_ridx   = 2'd0;
				next_state  = S_REPLY;
				next_status = ST_OK;
				if (!loader) begin
					if ((cmd_id == CMD_ENTER) && (pkt_len == LEN_SIMPLE)) begin
						next_loader = 1'b1;
					end else begin
						next_state = S_LEN;
					end
				end else if (!is_known(cmd_id)) begin
					next_status = ST_UNKNOWN;
				end else if ((cmd_id == CMD_FILL) ? !fill_count_ok
					: (pkt_len != exp_len(cmd_id))) begin
					next_status = ST_COUNT;
				end else begin
					case (cmd_id)
						CMD_LEAVE: begin
							if (unstable || !i_app_valid) begin
								next_status = ST_LEAVE;
							end else begin
								next_loader = 1'b0;
								next_sess   = 1'b0;
							end
						end
						CMD_OPEN: begin
							if (!aligned(open_start) || (open_end <= open_start)) begin
								next_status = ST_RANGE;
							end else begin
								next_sess       = 1'b1;
								next_unstable   = 1'b1;
								next_page_set   = 1'b0;
								next_sess_start = open_start;
								next_sess_end   = open_end;
							end
						end
						CMD_ADDR: begin
							if (!sess) begin
								next_status = ST_NOSESS;
							end else if (!aligned(arg_addr) || (arg_addr < sess_start)
								|| (arg_addr >= sess_end)) begin
								next_status = ST_RANGE;
							end else begin
								next_page_addr = arg_addr;
								next_page_set  = 1'b1;
							end
						end
						CMD_ERASE, CMD_COMMIT: begin
							if (!sess) begin
								next_status = ST_NOSESS;
							end else if (!page_set) begin
								next_status = ST_RANGE;
							end else begin
								next_op    = (cmd_id == CMD_ERASE) ? FOP_ERASE : FOP_PROGRAM;
								next_state = S_WAIT;
							end
						end
						CMD_FILL: begin
							if (!sess) begin
								next_status = ST_NOSESS;
							end else if (!fill_fits) begin
								next_status = ST_RANGE;
							end
						end
						CMD_CHECK: begin
							if (sess_end == 32'h0000_0000) begin
								next_status = ST_NOSESS;
							end else begin
								next_op    = FOP_CHECK;
								next_state = S_WAIT;
							end
						end
						CMD_READ: begin
							next_rd_left = {arg[1], arg[0]};
						end
						default: begin
							next_status = ST_OK;
						end
					endcase
				end
			end
			S_WAIT: begin
				if (i_flash_done) begin
					next_op    = FOP_NONE;
					next_state = S_REPLY;
					if (i_flash_fail) begin
						next_status = ST_FLASH;
					end else if (i_flash_sum_bad) begin
						next_status = ST_CSUM;
					end else if ((op == FOP_PROGRAM) && (({1'b0, page_addr}
						+ 33'(PAGE_BYTES)) >= {1'b0, sess_end})) begin
						next_unstable = 1'b0;
						next_sess     = 1'b0;
					end
				end
			end
			S_REPLY: begin
				if (tx_free) begin
					next_tx_full = 1'b1;
					next_ridx    = ridx + 2'd1;
					case (ridx)
						2'd0:    next_tx_data = REPLY_LEN;
						2'd1:    next_tx_data = cmd_id;
						2'd2:    next_tx_data = status;
						default: next_tx_data = LOADER_REV;
					endcase
					if (reply_last) begin
						if ((cmd_id == CMD_READ) && (status == ST_OK)
							&& (rd_left != 16'h0000) && loader) begin
							next_op    = FOP_READ;
							next_state = S_STREAM;
						end else begin
							next_state = S_LEN;
						end
					end
				end
			end
			default: begin
				if (rd_take) begin
					next_tx_full = 1'b1;
					next_tx_data = i_flash_rd.data;
					next_rd_left = rd_left - 16'd1;
					if (rd_left == 16'd1) begin
						next_op    = FOP_NONE;
						next_state = S_LEN;
					end
				end
			end
		endcase
	end

	// ==========================================================
	// USB re-enumeration timer
	always_comb begin
		next_det_cnt = det_cnt;
		if ((next_loader != loader) && i_usb_host) begin
			next_det_cnt = 16'(DETACH_CYC);
		end else if (det_cnt != 16'h0000) begin
			next_det_cnt = det_cnt - 16'd1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			state      <= S_LEN;
			pkt_len    <= 8'h00;
			rem        <= 8'h00;
			cmd_id     <= 8'h00;
			bidx       <= 8'h00;
			arg        <= '0;
			status     <= 8'h00;
			ridx       <= 2'd0;
			op         <= FOP_NONE;
			rd_left    <= 16'h0000;
			tx_full    <= 1'b0;
			tx_data    <= 8'h00;
			loader     <= 1'b0;
			sess       <= 1'b0;
			unstable   <= 1'b0;
			page_set   <= 1'b0;
			page_addr  <= 32'h0000_0000;
			sess_start <= 32'h0000_0000;
			sess_end   <= 32'h0000_0000;
			det_cnt    <= 16'h0000;
		end else begin
			state      <= next_state;
			pkt_len    <= next_pkt_len;
			rem        <= next_rem;
			cmd_id     <= next_cmd_id;
			bidx       <= next_bidx;
			arg        <= next_arg;
			status     <= next_status;
			ridx       <= next_ridx;
			op         <= next_op;
			rd_left    <= next_rd_left;
			tx_full    <= next_tx_full;
			tx_data    <= next_tx_data;
			loader     <= next_loader;
			sess       <= next_sess;
			unstable   <= next_unstable;
			page_set   <= next_page_set;
			page_addr  <= next_page_addr;
			sess_start <= next_sess_start;
			sess_end   <= next_sess_end;
			det_cnt    <= next_det_cnt;
		end
	end

	// ==========================================================
	// Outputs and buffer
	assign o_tx.valid           = tx_full;
	assign o_tx.data            = tx_data;
	assign o_flash_req.op       = op;
	assign o_flash_req.addr     = (op == FOP_CHECK) ? sess_start : page_addr;
	assign o_flash_req.end_addr = sess_end;
	assign o_flash_req.len      = (op == FOP_READ) ? rd_left : 16'h0000;
	assign o_loader_mode        = loader;
	assign o_usb_detach         = det_cnt != 16'h0000;
	// Arbitrary identity values, replaced per product
	assign o_usb_vid            = LOADER_VID;
	assign o_usb_pid            = LOADER_PID;

	fula_page_buf #(
		.DEPTH (PAGE_BYTES),
		.AW    (PAGE_AW)
	) u_buf (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_wr_en   (buf_wr),
		.i_wr_idx  (buf_idx),
		.i_wr_data (i_rx.data),
		.i_rd_idx  (i_buf_rd_idx),
		.o_rd_data (o_buf_rd_data)
	);

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);

	sequence s_load(logic [1:0] n);
		(state == S_REPLY) && tx_free && (ridx == n);
	endsequence

	sequence s_exec_known;
		(state == S_EXEC) && loader && is_known(cmd_id);
	endsequence

	enter_cmd_a: assert property ((state == S_EXEC) && !loader && (cmd_id == CMD_ENTER)
		&& (pkt_len == LEN_SIMPLE) |=> loader && (state == S_REPLY))
		else $error("enter command did not switch to loader");
	app_ignore_a: assert property ((state == S_EXEC) && !loader && (cmd_id != CMD_ENTER)
		|=> !loader && (state == S_LEN))
		else $error("loader command served in application mode");
	usb_detach_a: assert property ($changed(loader) && $past(i_usb_host)
		|-> o_usb_detach [*8])
		else $error("usb detach not held after mode change");
	unknown_id_a: assert property ((state == S_EXEC) && loader && !is_known(cmd_id)
		|=> status == ST_UNKNOWN)
		else $error("unknown identifier not reported");
	rom_guard_a: assert property ((op == FOP_ERASE) || (op == FOP_PROGRAM) |-> sess)
		else $error("rom modified without session");
	leave_hold_a: assert property (loader && unstable |=> loader)
		else $error("loader left while application unstable");
	page_align_a: assert property (page_set |-> (page_addr[PAGE_AW-1:0] == '0))
		else $error("held page address not page aligned");
	erase_req_a: assert property (s_exec_known ##0 (cmd_id == CMD_ERASE)
		&& (pkt_len == LEN_SIMPLE) && sess && page_set
		|=> (o_flash_req.op == FOP_ERASE) && (o_flash_req.addr == page_addr)
		until_with i_flash_done)
		else $error("erase request not held at page address");
	erase_done_a: assert property ((state == S_WAIT) |-> ##[0:1000] (state != S_WAIT))
		else $error("flash operation never completed");
	fill_write_a: assert property (buf_wr |-> sess && (cmd_id == CMD_FILL)
		&& (fill_size <= FILL_MAX) && ({8'h00, bidx} < fill_size + 16'h0004)
		&& (({1'b0, fill_off} + {9'h000, bidx}) < 17'(PAGE_BYTES) + 17'h00004))
		else $error("ram fill write outside limits");
	flash_fail_a: assert property ((state == S_WAIT) && i_flash_done && i_flash_fail
		|=> (status == ST_FLASH) && (state == S_REPLY))
		else $error("flash failure not reported");
	reply_frame_a: assert property (s_load(2'd0)
		|=> o_tx.valid && (o_tx.data == REPLY_LEN))
		else $error("reply length byte wrong");
	reply_echo_a: assert property (s_load(2'd1)
		|=> o_tx.valid && (o_tx.data == cmd_id))
		else $error("reply identifier not echoed");
	count_err_a: assert property (s_exec_known ##0 (cmd_id != CMD_FILL)
		&& (pkt_len != exp_len(cmd_id)) |=> status == ST_COUNT)
		else $error("wrong byte count not reported");
endmodule

// ===== test/fula_flash_model.sv
// Behavioural flash engine that answers the loader's requests
`timescale 1ns/1ps
module fula_flash_model (
	// Clock and reset
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_rstn,
	// Requests and outcome selection
	input  wire fula_pkg::fula_flash_req_t i_req,
	input  wire logic [1:0]            i_mode,
	input  wire logic                  i_rd_ready,
	// Answers
	output logic                       o_done,
	output logic                       o_fail,
	output logic                       o_sum_bad,
	output fula_pkg::fula_byte_t       o_rd
);
	import fula_pkg::*;

	logic [2:0] cnt;
	logic [7:0] seq;

	// ==========================================================
	// Slow completion: four cycles per erase, program or check operation
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt <= 3'h0;
			seq <= 8'h30;
		end else begin
			cnt <= (i_req.op inside {FOP_ERASE, FOP_PROGRAM, FOP_CHECK} && !o_done) ? cnt + 3'h1 : 3'h0;
			if (o_rd.valid && i_rd_ready) begin
				seq <= seq + 8'h01;
			end
		end
	end
	assign o_done    = (cnt == 3'h4);
	assign o_fail    = o_done & i_mode[0];
	assign o_sum_bad = o_done & i_mode[1];
	// Idle read data is the inverted sequence byte so stale values never match
	assign o_rd.valid = (i_req.op == FOP_READ);
	assign o_rd.data  = o_rd.valid ? seq : ~seq;
endmodule

// ===== test/flash_update_loader_tb.sv
// Self-checking bench for the loader command interpreter
`timescale 1ns/1ps
module flash_update_loader_tb;
	import fula_pkg::*;

	logic            clk = 0;
	logic            rstn = 0;
	fula_byte_t      rx = '0;
	logic            rx_ready, flash_rd_ready, loader_mode, usb_detach;
	fula_byte_t      tx, flash_rd;
	logic            tx_ready = 1;
	fula_flash_req_t req;
	logic            done, fail, sum_bad;
	logic [1:0]      mode = 2'h0;
	logic [11:0]     buf_idx = 12'h000;
	logic [7:0]      buf_data;
	logic            app_valid = 0, usb_host = 0;
	logic [15:0]     vid, pid;
	int              bad_count = 0, checks = 0;

	always #50 clk = ~clk;

	fula_loader #(.DETACH_CYC(8), .LOADER_REV(8'h5A), .LOADER_VID(16'hA5C3),
		.LOADER_PID(16'h3C5A)) dut (
		.i_clk_sys(clk), .i_rstn(rstn), .i_rx(rx), .o_rx_ready(rx_ready), .o_tx(tx),
		.i_tx_ready(tx_ready), .o_flash_req(req), .i_flash_done(done), .i_flash_fail(fail),
		.i_flash_sum_bad(sum_bad), .i_flash_rd(flash_rd), .o_flash_rd_ready(flash_rd_ready),
		.i_buf_rd_idx(buf_idx), .o_buf_rd_data(buf_data), .i_app_valid(app_valid),
		.i_usb_host(usb_host), .o_loader_mode(loader_mode), .o_usb_detach(usb_detach),
		.o_usb_vid(vid), .o_usb_pid(pid));

	fula_flash_model flash (
		.i_clk_sys(clk), .i_rstn(rstn), .i_req(req), .i_mode(mode),
		.i_rd_ready(flash_rd_ready), .o_done(done), .o_fail(fail), .o_sum_bad(sum_bad),
		.o_rd(flash_rd));

	// ==========================================================
	// Helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic pkt(input logic [7:0] q[$]);
		int n;
		foreach (q[i]) begin
			rx.valid = 1'b1;
			rx.data  = q[i];
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (rx_ready !== 1'b1 && n < 500);
			if (rx_ready !== 1'b1) begin
				bad_count++;
			end
			#10;
		end
		rx.valid = 1'b0;
	endtask

	task automatic get(output logic [7:0] b);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (tx.valid !== 1'b1 && n < 500);
		if (tx.valid !== 1'b1) begin
			bad_count++;
		end
		b = tx.data;
		#10;
	endtask

	task automatic reply(input logic [7:0] id, input logic [7:0] st);
		logic [7:0] b;
		get(b);
		chk("reply length", REPLY_LEN, b);
		get(b);
		chk("reply id", id, b);
		get(b);
		chk("reply status", st, b);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_enter();
		int n;
		pkt('{8'h01, CMD_VERSION});
		n = 0;
		repeat (20) begin
			@(posedge clk);
			n += (tx.valid === 1'b1);
		end
		chk("application mode silent", 0, n);
		chk("application mode", 0, loader_mode);
		#10;
		usb_host = 1'b1;
		pkt('{LEN_SIMPLE, CMD_ENTER});
		reply(CMD_ENTER, ST_OK);
		chk("loader mode", 1, loader_mode);
		chk("usb detach", 1, usb_detach);
		chk("usb identity", 32'hA5C33C5A, {vid, pid});
		usb_host = 1'b0;
		repeat (8) @(posedge clk);
		chk("usb detach end", 0, usb_detach);
		#10;
		$display("test enter done");
	endtask

	task automatic t_refuse();
		pkt('{LEN_SIMPLE, CMD_ERASE});
		reply(CMD_ERASE, ST_NOSESS);
		pkt('{LEN_SIMPLE, 8'h20});
		reply(8'h20, ST_UNKNOWN);
		pkt('{8'h02, CMD_ERASE, 8'h00});
		reply(CMD_ERASE, ST_COUNT);
		pkt('{LEN_ADDR, CMD_ADDR, 8'h00, 8'h00, 8'h00, 8'h00});
		reply(CMD_ADDR, ST_NOSESS);
		$display("test refuse done");
	endtask

	task automatic t_page();
		logic [31:0] seen;
		logic [7:0]  big[$];
		pkt('{LEN_OPEN, CMD_OPEN, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00});
		reply(CMD_OPEN, ST_OK);
		app_valid = 1'b1;
		pkt('{LEN_SIMPLE, CMD_LEAVE});
		reply(CMD_LEAVE, ST_LEAVE);
		pkt('{LEN_ADDR, CMD_ADDR, 8'h00, 8'h01, 8'h00, 8'h00});
		reply(CMD_ADDR, ST_RANGE);
		pkt('{LEN_ADDR, CMD_ADDR, 8'h00, 8'h00, 8'h00, 8'h00});
		reply(CMD_ADDR, ST_OK);
		pkt('{LEN_SIMPLE, CMD_ERASE});
		wait (req.op == FOP_ERASE);
		seen = req.addr;
		chk("erase end", 32'h0000_1000, req.end_addr);
		reply(CMD_ERASE, ST_OK);
		chk("erase address", 0, seen);
		pkt('{8'h07, CMD_FILL, 8'h02, 8'h00, 8'h03, 8'h00, 8'hAA, 8'hBB});
		reply(CMD_FILL, ST_OK);
		buf_idx = 12'h004;
		repeat (2) @(posedge clk);
		chk("buffer byte", 8'hBB, buf_data);
		#10;
		big = '{8'h3C, CMD_FILL, 8'h37, 8'h00, 8'h00, 8'h00};
		repeat (55) big.push_back(8'h00);
		pkt(big);
		reply(CMD_FILL, ST_COUNT);
		mode = 2'h1;
		pkt('{LEN_SIMPLE, CMD_COMMIT});
		reply(CMD_COMMIT, ST_FLASH);
		mode = 2'h0;
		pkt('{LEN_SIMPLE, CMD_COMMIT});
		reply(CMD_COMMIT, ST_OK);
		$display("test page done");
	endtask

	task automatic t_query();
		logic [7:0] b;
		mode = 2'h2;
		pkt('{LEN_SIMPLE, CMD_CHECK});
		reply(CMD_CHECK, ST_CSUM);
		mode = 2'h0;
		pkt('{LEN_SIMPLE, CMD_VERSION});
		reply(CMD_VERSION, ST_OK);
		get(b);
		chk("revision", 8'h5A, b);
		pkt('{LEN_READ, CMD_READ, 8'h02, 8'h00});
		reply(CMD_READ, ST_OK);
		get(b);
		chk("read byte 0", 8'h30, b);
		get(b);
		chk("read byte 1", 8'h31, b);
		pkt('{LEN_SIMPLE, CMD_LEAVE});
		reply(CMD_LEAVE, ST_OK);
		repeat (2) @(posedge clk);
		chk("application mode", 0, loader_mode);
		$display("test query done");
	endtask

	// ==========================================================
	// Verdict
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#(100 * 20000);
		bad_count++;
		finish_test();
	end

	initial begin
		repeat (10) @(posedge clk);
		#10 rstn = 1'b1;
		@(posedge clk);
		#10;
		t_enter();
		t_refuse();
		t_page();
		t_query();
		finish_test();
	end
endmodule
